/* logic/bfm_pkg.sv */
`default_nettype none
package bfm_pkg;

    // Port data width and default queue depth
    localparam int DATA_W    = 36;
    localparam int DEF_DEPTH = 1024;

    // Bus size encodings and usable mail widths
    localparam logic [1:0] BUS_SIZE_36 = 2'h0;
    localparam logic [1:0] BUS_SIZE_18 = 2'h1;
    localparam logic [1:0] BUS_SIZE_9  = 2'h2;
    localparam int         MAIL_W_18   = 18;
    localparam int         MAIL_W_9    = 9;

    // Reset values of flags
    localparam logic MAIL_FLAG_RST  = 1'b1;
    localparam logic SPACE_FLAG_RST = 1'b0;
    localparam logic HIGH_FILL_RST  = 1'b1;
    localparam logic LOW_FILL_RST   = 1'b0;

    // Pins of one synchronous port, input side
    typedef struct packed {
        logic              port_clk;
        logic              chip_sel_n;
        logic              dir_sel;
        logic              xfer_en;
        logic              mail_select;
        logic [1:0]        bus_size;
        logic [DATA_W-1:0] data;
    } bfm_port_pins_t;

endpackage
`default_nettype wire

/* logic/bfm_flags_mailbox.sv */
// Summary of operation
// - Space flag high while a location is free; writes ignored while low.
// - Space flag serves as input ready or full flag, same meaning both modes.
// - Space flag runs on writer port edges; write pointer counts each accepted word.
// - Space flag compares write and read pointers for a full queue only.
// - After a freeing read, space flag rises on second writer port edge.
// - Low fill flag runs on reader port edges, offset per queue.
// - Low fill flag low at offset words or fewer, high above.
// - Low fill flag rises on second reader edge after the filling write.
// - Offset registers take their values while the queue is held in reset.
// - High fill flag runs on writer port edges, offset per queue.
// - High fill flag low when count reaches depth minus offset, else high.
// - High fill flag rises on second writer edge after the lowering read.
// - One 36-bit mail register per direction, chosen by mail select.
// - Port A mail write captures port A data into the A-to-B mail register.
// - Mail register keeps only the writing port's bus size bits.
// - Port B mail write captures port B data into the B-to-A mail register.
// - Mail write drives its flag low; further writes ignored while low.
// - Driven data comes from queue output or incoming mail, by mail select.
// - Port B mail read sets the A-to-B mail flag high.
// - Port A mail read sets the B-to-A mail flag high.
// - Mail data survives reads and changes only on an accepted write.
`timescale 1ns/10ps
`default_nettype none
module bfm_flags_mailbox
    import bfm_pkg::*;
#(
    parameter  int DEPTH = DEF_DEPTH,
    localparam int AW    = $clog2(DEPTH),
    localparam int PW    = AW + 1
)
(
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_RESETN,
    input  wire logic              I_CLK_EN,
    input  wire bfm_port_pins_t    I_PORTA_PINS,
    input  wire bfm_port_pins_t    I_PORTB_PINS,
    input  wire logic              I_Q1_RESETN,
    input  wire logic              I_Q2_RESETN,
    input  wire logic [AW-1:0]     I_Q1_LOW_FILL_OFFSET,
    input  wire logic [AW-1:0]     I_Q1_HIGH_FILL_OFFSET,
    input  wire logic [AW-1:0]     I_Q2_LOW_FILL_OFFSET,
    input  wire logic [AW-1:0]     I_Q2_HIGH_FILL_OFFSET,
    input  wire logic [DATA_W-1:0] I_PORTA_QUEUE_DATA,
    input  wire logic [DATA_W-1:0] I_PORTB_QUEUE_DATA,
    output var  logic [DATA_W-1:0] O_PORTA_DATA,
    output var  logic              O_PORTA_DATA_OE,
    output var  logic [DATA_W-1:0] O_PORTB_DATA,
    output var  logic              O_PORTB_DATA_OE,
    output var  logic              O_PORTA_SPACE_FLAG,
    output var  logic              O_PORTB_SPACE_FLAG,
    output var  logic              O_PORTA_HIGH_FILL_FLAG,
    output var  logic              O_PORTB_HIGH_FILL_FLAG,
    output var  logic              O_PORTA_LOW_FILL_FLAG,
    output var  logic              O_PORTB_LOW_FILL_FLAG,
    output var  logic              O_A2B_MAIL_FLAG,
    output var  logic              O_B2A_MAIL_FLAG,
    output var  logic              O_Q1_WRITE_STB,
    output var  logic              O_Q1_READ_STB,
    output var  logic              O_Q2_WRITE_STB,
    output var  logic              O_Q2_READ_STB
);

    localparam int              PB      = $bits(bfm_port_pins_t);
    localparam int              SW      = 2 * PB + 2;
    localparam logic [PW-1:0]   DEPTH_W = PW'(DEPTH);
    localparam logic [PW:0]     DEPTH_X = (PW + 1)'(DEPTH);
    // Synchroniser resets to idle pins, port deselected, so no enable glitch follows reset
    localparam bfm_port_pins_t  PIN_IDLE  = '{chip_sel_n: 1'b1, default: '0};
    localparam logic [SW-1:0]   SYNC_IDLE = {2'h0, PIN_IDLE, PIN_IDLE};

    // Binary to gray
    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    // Gray to binary
    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Keeps the bits that a bus size uses
    function automatic logic [DATA_W-1:0] size_mask(input logic [1:0] sz);
        logic [DATA_W-1:0] m;
        m = '1;
        if (sz == BUS_SIZE_18)
        begin
            m = {{(DATA_W - MAIL_W_18){1'b0}}, {MAIL_W_18{1'b1}}};
        end
        else if (sz == BUS_SIZE_9)
        begin
            m = {{(DATA_W - MAIL_W_9){1'b0}}, {MAIL_W_9{1'b1}}};
        end
        return m;
    endfunction

    logic [SW-1:0]     pin_raw;
    logic [SW-1:0]     s1_q;
    logic [SW-1:0]     s2_q;
    logic [SW-1:0]     s3_q;
    logic [SW-1:0]     filt_q;
    bfm_port_pins_t    pins_f [2];
    logic [1:0]        qrst_n;
    logic [1:0]        edge_v;
    logic [1:0]        wr_sel;
    logic [1:0]        rd_sel;
    logic [1:0]        space_v;
    logic [1:0]        high_v;
    logic [1:0]        low_v;
    logic [1:0]        mflag_v;
    logic [1:0]        wstb_v;
    logic [1:0]        rstb_v;
    logic [DATA_W-1:0] mail_v  [2];
    logic [DATA_W-1:0] qdata_v [2];
    logic [AW-1:0]     off_lo_in [2];
    logic [AW-1:0]     off_hi_in [2];
    logic [DATA_W-1:0] dout_v  [2];
    logic [1:0]        oe_v;

    assign pin_raw      = {I_Q2_RESETN, I_Q1_RESETN, I_PORTB_PINS, I_PORTA_PINS};
    assign pins_f[0]    = filt_q[PB-1:0];
    assign pins_f[1]    = filt_q[2*PB-1:PB];
    assign qrst_n       = filt_q[SW-1:2*PB];
    assign qdata_v[0]   = I_PORTA_QUEUE_DATA;
    assign qdata_v[1]   = I_PORTB_QUEUE_DATA;
    assign off_lo_in[0] = I_Q1_LOW_FILL_OFFSET;
    assign off_lo_in[1] = I_Q2_LOW_FILL_OFFSET;
    assign off_hi_in[0] = I_Q1_HIGH_FILL_OFFSET;
    assign off_hi_in[1] = I_Q2_HIGH_FILL_OFFSET;

    // Three-stage pin synchroniser; a level counts once stages two and three agree
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            s1_q   <= SYNC_IDLE;
            s2_q   <= SYNC_IDLE;
            s3_q   <= SYNC_IDLE;
            filt_q <= SYNC_IDLE;
        end
        else if (I_CLK_EN)
        begin
            s1_q   <= pin_raw;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
        end
    end

    // Port decode: edge detect, transfer select, data drive
    for (genvar p = 0; p < 2; p++)
    begin : g_port
        logic              clk_prev_q;
        logic              wr_dir;
        logic              xfer;
        logic [DATA_W-1:0] dout_q;
        logic              oe_q;

        // Port B direction select is inverted against port A
        assign wr_dir    = (p == 0) ? pins_f[p].dir_sel : ~pins_f[p].dir_sel;
        assign xfer      = ~pins_f[p].chip_sel_n & pins_f[p].xfer_en & edge_v[p];
        assign edge_v[p] = pins_f[p].port_clk & ~clk_prev_q;
        assign wr_sel[p] = xfer & wr_dir;
        assign rd_sel[p] = xfer & ~wr_dir;
        assign dout_v[p] = dout_q;
        assign oe_v[p]   = oe_q;

        // Previous port clock level
        always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
        begin
            if (!I_RESETN)
            begin
                clk_prev_q <= 1'b0;
            end
            else if (I_CLK_EN)
            begin
                clk_prev_q <= pins_f[p].port_clk;
            end
        end

        // Drive data while selected for reading, from queue or incoming mail
        always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
        begin
            if (!I_RESETN)
            begin
                dout_q <= '0;
                oe_q   <= 1'b0;
            end
            else if (I_CLK_EN)
            begin
                oe_q   <= ~pins_f[p].chip_sel_n & ~wr_dir;
                dout_q <= pins_f[p].mail_select ? mail_v[1-p] : qdata_v[p];
            end
        end
    end

    // Queue flags; queue q is written by port q and read by the other port
    for (genvar q = 0; q < 2; q++)
    begin : g_queue
        logic [PW-1:0] wptr_q;
        logic [PW-1:0] wgray_q;
        logic [PW-1:0] wsync_q;
        logic [PW-1:0] rptr_q;
        logic [PW-1:0] rgray_q;
        logic [PW-1:0] rsync_q;
        logic [AW-1:0] off_lo_q;
        logic [AW-1:0] off_hi_q;
        logic          space_q;
        logic          high_q;
        logic          low_q;
        logic          nonempty_q;
        logic          wstb_q;
        logic          rstb_q;
        logic          wr_acc;
        logic          rd_acc;
        logic [PW-1:0] wptr_nxt;
        logic [PW-1:0] rptr_nxt;
        logic [PW-1:0] wcount;
        logic [PW-1:0] rcount;

        // Writes only while space is flagged
        assign wr_acc   = wr_sel[q] & ~pins_f[q].mail_select & space_q;
        assign rd_acc   = rd_sel[1-q] & ~pins_f[1-q].mail_select & nonempty_q;
        assign wptr_nxt = wptr_q + PW'(wr_acc);
        assign rptr_nxt = rptr_q + PW'(rd_acc);
        // Fill level seen by each side from the delayed far pointer
        assign wcount   = wptr_nxt - gray2bin(wsync_q);
        assign rcount   = gray2bin(rsync_q) - rptr_nxt;
        assign space_v[q] = space_q;
        assign high_v[q]  = high_q;
        assign low_v[q]   = low_q;
        assign wstb_v[q]  = wstb_q;
        assign rstb_v[q]  = rstb_q;

        // Offsets take their values while the queue is held in reset
        always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
        begin
            if (!I_RESETN)
            begin
                off_lo_q <= '0;
                off_hi_q <= '0;
            end
            else if (I_CLK_EN && !qrst_n[q])
            begin
                off_lo_q <= off_lo_in[q];
                off_hi_q <= off_hi_in[q];
            end
        end

        // Writer side, stepped on writer port clock edges
        always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
        begin
            if (!I_RESETN)
            begin
                wptr_q  <= '0;
                wgray_q <= '0;
                wsync_q <= '0;
                space_q <= SPACE_FLAG_RST;
                high_q  <= HIGH_FILL_RST;
                wstb_q  <= 1'b0;
            end
            else if (I_CLK_EN)
            begin
                wstb_q <= 1'b0;
                if (!qrst_n[q])
                begin
                    wptr_q  <= '0;
                    wgray_q <= '0;
                    wsync_q <= '0;
                    space_q <= SPACE_FLAG_RST;
                    high_q  <= HIGH_FILL_RST;
                end
                else if (edge_v[q])
                begin
                    wstb_q  <= wr_acc;
                    wptr_q  <= wptr_nxt;
                    wgray_q <= bin2gray(wptr_nxt);
                    wsync_q <= rgray_q;
                    // Same sense for input-ready and full use; rises one edge after capture
                    space_q <= (wcount != DEPTH_W);
                    high_q  <= ({1'b0, wcount} + {{(PW - AW + 1){1'b0}}, off_hi_q})
                               < DEPTH_X;
                end
            end
        end

        // Reader side, stepped on reader port clock edges
        always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
        begin
            if (!I_RESETN)
            begin
                rptr_q     <= '0;
                rgray_q    <= '0;
                rsync_q    <= '0;
                low_q      <= LOW_FILL_RST;
                nonempty_q <= 1'b0;
                rstb_q     <= 1'b0;
            end
            else if (I_CLK_EN)
            begin
                rstb_q <= 1'b0;
                if (!qrst_n[q])
                begin
                    rptr_q     <= '0;
                    rgray_q    <= '0;
                    rsync_q    <= '0;
                    low_q      <= LOW_FILL_RST;
                    nonempty_q <= 1'b0;
                end
                else if (edge_v[1-q])
                begin
                    rstb_q     <= rd_acc;
                    rptr_q     <= rptr_nxt;
                    rgray_q    <= bin2gray(rptr_nxt);
                    rsync_q    <= wgray_q;
                    nonempty_q <= (rcount != '0);
                    low_q      <= (rcount > {{(PW - AW){1'b0}}, off_lo_q});
                end
            end
        end
    end

    // Mail registers; direction m is written by port m and read by the other
    for (genvar m = 0; m < 2; m++)
    begin : g_mail
        logic [DATA_W-1:0] mail_q;
        logic              mflag_q;
        logic              mwr;
        logic              mrd;

        // Writes ignored while the flag shows unread mail
        assign mwr        = wr_sel[m] & pins_f[m].mail_select & mflag_q;
        assign mrd        = rd_sel[1-m] & pins_f[1-m].mail_select;
        assign mail_v[m]  = mail_q;
        assign mflag_v[m] = mflag_q;

        // Mail data changes only on an accepted write
        always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
        begin
            if (!I_RESETN)
            begin
                mail_q <= '0;
            end
            else if (I_CLK_EN && mwr)
            begin
                mail_q <= pins_f[m].data & size_mask(pins_f[m].bus_size);
            end
        end

        // Flag low on write, high when the other port reads the mail
        always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
        begin
            if (!I_RESETN)
            begin
                mflag_q <= MAIL_FLAG_RST;
            end
            else if (I_CLK_EN)
            begin
                if (mwr)
                begin
                    mflag_q <= 1'b0;
                end
                else if (mrd)
                begin
                    mflag_q <= 1'b1;
                end
            end
        end
    end

    // Outputs, all straight from registers
    assign O_PORTA_DATA           = dout_v[0];
    assign O_PORTA_DATA_OE        = oe_v[0];
    assign O_PORTB_DATA           = dout_v[1];
    assign O_PORTB_DATA_OE        = oe_v[1];
    assign O_PORTA_SPACE_FLAG     = space_v[0];
    assign O_PORTB_SPACE_FLAG     = space_v[1];
    assign O_PORTA_HIGH_FILL_FLAG = high_v[0];
    assign O_PORTB_HIGH_FILL_FLAG = high_v[1];
    assign O_PORTA_LOW_FILL_FLAG  = low_v[1];
    assign O_PORTB_LOW_FILL_FLAG  = low_v[0];
    assign O_A2B_MAIL_FLAG        = mflag_v[0];
    assign O_B2A_MAIL_FLAG        = mflag_v[1];
    assign O_Q1_WRITE_STB         = wstb_v[0];
    assign O_Q1_READ_STB          = rstb_v[0];
    assign O_Q2_WRITE_STB         = wstb_v[1];
    assign O_Q2_READ_STB          = rstb_v[1];

endmodule
`default_nettype wire

/* tb/bfm_flags_mailbox_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module bfm_flags_mailbox_properties
    import bfm_pkg::*;
(
    input  wire logic           I_SYS_CLK,
    input  wire logic           I_RESETN,
    input  wire bfm_port_pins_t I_PORTA_PINS,
    input  wire bfm_port_pins_t I_PORTB_PINS,
    input  wire logic           I_Q1_RESETN,
    input  wire logic           I_Q2_RESETN,
    input  wire logic           O_PORTA_SPACE_FLAG,
    input  wire logic           O_PORTA_HIGH_FILL_FLAG,
    input  wire logic           O_PORTA_LOW_FILL_FLAG,
    input  wire logic           O_PORTB_LOW_FILL_FLAG,
    input  wire logic           O_A2B_MAIL_FLAG,
    input  wire logic           O_B2A_MAIL_FLAG,
    input  wire logic           O_Q1_WRITE_STB
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESETN);

    // Port clock rise with a selected, enabled request on the pins
    logic [1:0]      clk_q;
    logic [8:0][7:0] h_q;
    wire logic       a_go = I_PORTA_PINS.port_clk && !clk_q[0] && !I_PORTA_PINS.chip_sel_n
                            && I_PORTA_PINS.xfer_en;
    wire logic       b_go = I_PORTB_PINS.port_clk && !clk_q[1] && !I_PORTB_PINS.chip_sel_n
                            && I_PORTB_PINS.xfer_en;
    wire logic       a_mb = I_PORTA_PINS.mail_select;
    wire logic       b_mb = I_PORTB_PINS.mail_select;
    wire logic       a_wr = I_PORTA_PINS.dir_sel;
    wire logic       b_wr = !I_PORTB_PINS.dir_sel;
    // Events: 0 A edge, 1 B edge, 2 B mail write, 3 B mail read, 4 A mail write,
    // 5 A mail read, 6 A queue write, 7 queue 1 out of reset, 8 queue 2 out of reset
    wire logic [8:0] ev = {I_Q2_RESETN, I_Q1_RESETN, a_go && a_wr && !a_mb,
                           a_go && !a_wr && a_mb, a_go && a_wr && a_mb,
                           b_go && !b_wr && b_mb, b_go && b_wr && b_mb,
                           I_PORTB_PINS.port_clk && !clk_q[1],
                           I_PORTA_PINS.port_clk && !clk_q[0]};

    // Eight-cycle histories bridge the pin filter latency
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            clk_q <= 2'h0;
            h_q   <= '0;
        end
        else
        begin
            clk_q <= {I_PORTB_PINS.port_clk, I_PORTA_PINS.port_clk};
            for (int i = 0; i < 9; i++)
                h_q[i] <= {h_q[i][6:0], ev[i]};
        end
    end

    a2b_mail_fill_a: assert property ($fell(O_A2B_MAIL_FLAG) |-> |h_q[4])
        else $error("A-to-B mail flag fell without a port A mail write");
    a2b_mail_read_a: assert property ($rose(O_A2B_MAIL_FLAG) |-> |h_q[3])
        else $error("A-to-B mail flag rose without a port B mail read");
    b2a_mail_fill_a: assert property ($fell(O_B2A_MAIL_FLAG) |-> |h_q[2])
        else $error("B-to-A mail flag fell without a port B mail write");
    b2a_mail_read_a: assert property ($rose(O_B2A_MAIL_FLAG) |-> |h_q[5])
        else $error("B-to-A mail flag rose without a port A mail read");
    q1_write_room_a: assert property (O_Q1_WRITE_STB |-> $past(O_PORTA_SPACE_FLAG) && |h_q[6])
        else $error("Queue 1 write taken without room or request");
    q1_write_pulse_a: assert property (O_Q1_WRITE_STB |=> !O_Q1_WRITE_STB [*4])
        else $error("Queue 1 write strobe longer than one word");
    space_a_sync_a: assert property ($changed(O_PORTA_SPACE_FLAG) && &h_q[7] |-> |h_q[0])
        else $error("Port A space flag moved without a port A edge");
    high_fill_sync_a: assert property ($changed(O_PORTA_HIGH_FILL_FLAG) && &h_q[7] |-> |h_q[0])
        else $error("Port A high fill flag moved without a port A edge");
    low_fill_b_sync_a: assert property ($changed(O_PORTB_LOW_FILL_FLAG) && &h_q[7] |-> |h_q[1])
        else $error("Port B low fill flag moved without a port B edge");
    low_fill_a_sync_a: assert property ($changed(O_PORTA_LOW_FILL_FLAG) && &h_q[8] |-> |h_q[0])
        else $error("Port A low fill flag moved without a port A edge");
endmodule
bind bfm_flags_mailbox bfm_flags_mailbox_properties chk_u (.I_SYS_CLK, .I_RESETN,
    .I_PORTA_PINS, .I_PORTB_PINS, .I_Q1_RESETN, .I_Q2_RESETN, .O_PORTA_SPACE_FLAG,
    .O_PORTA_HIGH_FILL_FLAG, .O_PORTA_LOW_FILL_FLAG, .O_PORTB_LOW_FILL_FLAG,
    .O_A2B_MAIL_FLAG, .O_B2A_MAIL_FLAG, .O_Q1_WRITE_STB);
`default_nettype wire

/* tb/bfm_port_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bfm_port_model
    import bfm_pkg::*;
#(
    parameter logic WR_DIR = 1'b1
)
(
    input  wire logic           i_clk,
    output var  bfm_port_pins_t o_pins
);
    // Idle bus: port deselected, port clock low; timing mode held fixed, no mode pin
    initial
    begin
        o_pins = '0;
        o_pins.chip_sel_n = 1'b1;
    end

    // One port clock cycle; request fields held through the rising edge
    task automatic xfer(input logic cs_n, input logic dir, input logic en, input logic mb,
                        input logic [1:0] sz, input logic [DATA_W-1:0] d);
        @(negedge i_clk);
        o_pins.chip_sel_n  <= cs_n;
        o_pins.dir_sel     <= dir;
        o_pins.xfer_en     <= en;
        o_pins.mail_select <= mb;
        o_pins.bus_size    <= sz;
        o_pins.data        <= (dir == WR_DIR) ? d : ~o_pins.data; // Released bus flips
        repeat (3) @(negedge i_clk);
        o_pins.port_clk <= 1'b1;
        repeat (4) @(negedge i_clk);
        o_pins.port_clk <= 1'b0;
        repeat (4) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

/* tb/bfm_flags_mailbox_test.sv */
`timescale 1ns/10ps
`default_nettype none
module bfm_flags_mailbox_test
    import bfm_pkg::*;
;
    localparam int DEPTH = 16;
    typedef struct packed {
        logic              a2b;
        logic [1:0]        sz;
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] e;
    } bfm_row_t;
    logic              clk, rst_n, q1_rst_n, q2_rst_n, clk_en;
    bfm_port_pins_t    pins_a, pins_b;
    logic [DATA_W-1:0] qd_a, qd_b, da, db;
    logic              sp_a, sp_b, hf_a, hf_b, lf_a, lf_b, mf_ab, mf_ba, oe_a, oe_b;
    logic [3:0]        stb;
    int                n_fail = 0, checks = 0, cyc = 0;
    int                cnt [4] = '{default: 0};
    bfm_row_t          rows [6];

    bfm_port_model #(.WR_DIR(1'b1)) mdl_a (.i_clk(clk), .o_pins(pins_a));
    bfm_port_model #(.WR_DIR(1'b0)) mdl_b (.i_clk(clk), .o_pins(pins_b));
    bfm_flags_mailbox #(.DEPTH(DEPTH)) dut_u (.I_SYS_CLK(clk), .I_RESETN(rst_n),
        .I_CLK_EN(clk_en), .I_PORTA_PINS(pins_a), .I_PORTB_PINS(pins_b),
        .I_Q1_RESETN(q1_rst_n), .I_Q2_RESETN(q2_rst_n), .I_Q1_LOW_FILL_OFFSET(4'h3),
        .I_Q1_HIGH_FILL_OFFSET(4'h4), .I_Q2_LOW_FILL_OFFSET(4'h0),
        .I_Q2_HIGH_FILL_OFFSET(4'hf), .I_PORTA_QUEUE_DATA(qd_a), .I_PORTB_QUEUE_DATA(qd_b),
        .O_PORTA_DATA(da), .O_PORTA_DATA_OE(oe_a), .O_PORTB_DATA(db), .O_PORTB_DATA_OE(oe_b),
        .O_PORTA_SPACE_FLAG(sp_a), .O_PORTB_SPACE_FLAG(sp_b), .O_PORTA_HIGH_FILL_FLAG(hf_a),
        .O_PORTB_HIGH_FILL_FLAG(hf_b), .O_PORTA_LOW_FILL_FLAG(lf_a),
        .O_PORTB_LOW_FILL_FLAG(lf_b), .O_A2B_MAIL_FLAG(mf_ab), .O_B2A_MAIL_FLAG(mf_ba),
        .O_Q1_WRITE_STB(stb[0]), .O_Q1_READ_STB(stb[1]), .O_Q2_WRITE_STB(stb[2]),
        .O_Q2_READ_STB(stb[3]));

    // System clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Strobe counters and run-time ceiling
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        for (int i = 0; i < 4; i++)
            cnt[i] <= cnt[i] + int'(stb[i]);
        if (cyc == 20000)
        begin
            n_fail++;
            end_sim();
        end
    end

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pa(input logic dir, input logic mb, input logic [1:0] sz,
                      input logic [DATA_W-1:0] d);
        mdl_a.xfer(1'b0, dir, 1'b1, mb, sz, d);
    endtask

    task automatic pb(input logic dir, input logic mb, input logic [1:0] sz,
                      input logic [DATA_W-1:0] d);
        mdl_b.xfer(1'b0, dir, 1'b1, mb, sz, d);
    endtask

    // Idle port clock edges with the port deselected
    task automatic ia(input int n);
        repeat (n) mdl_a.xfer(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, '0);
    endtask

    task automatic ib(input int n);
        repeat (n) mdl_b.xfer(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, '0);
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        rows = '{'{1'b1, BUS_SIZE_36, 36'h9a5c3e71b, 36'h9a5c3e71b},
                 '{1'b1, BUS_SIZE_18, 36'hfffffffff, 36'h00003ffff},
                 '{1'b1, BUS_SIZE_9, 36'h555555555, 36'h000000155},
                 '{1'b0, BUS_SIZE_36, 36'h612345678, 36'h612345678},
                 '{1'b0, BUS_SIZE_18, 36'habcdef012, 36'h00002f012},
                 '{1'b0, BUS_SIZE_9, 36'h7000003ff, 36'h0000001ff}};
        rst_n = 1'b0;
        q1_rst_n = 1'b0;
        clk_en = 1'b1;
        q2_rst_n = 1'b0;
        qd_a = 36'h123456789;
        qd_b = 36'hdcba98765;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        q1_rst_n = 1'b1;
        q2_rst_n = 1'b1;
        repeat (6) @(negedge clk);
        chk({sp_a, sp_b, hf_a, hf_b, lf_a, lf_b, mf_ab, mf_ba}, 8'h33);
        ia(1);
        ib(1);
        chk({sp_a, sp_b}, 2'h3);
        // Mail rows: second write refused, reads repeat the same word
        foreach (rows[i])
        begin
            for (int k = 0; k < 2; k++)
            begin
                if (rows[i].a2b) pa(1'b1, 1'b1, rows[i].sz, k ? ~rows[i].d : rows[i].d);
                else pb(1'b0, 1'b1, rows[i].sz, k ? ~rows[i].d : rows[i].d);
                chk(rows[i].a2b ? mf_ab : mf_ba, 1'b0);
            end
            for (int k = 0; k < 2; k++)
            begin
                if (rows[i].a2b) pb(1'b1, 1'b1, BUS_SIZE_36, '0);
                else pa(1'b0, 1'b1, BUS_SIZE_36, '0);
                chk(rows[i].a2b ? db : da, rows[i].e);
                chk({oe_a, oe_b}, rows[i].a2b ? 2'h1 : 2'h2);
                chk(rows[i].a2b ? mf_ab : mf_ba, 1'b1);
            end
        end
        // Fill queue 1 to the top; low fill flag lags by two port B edges
        for (int n = 1; n <= DEPTH; n++)
        begin
            pa(1'b1, 1'b0, BUS_SIZE_36, 36'(n));
            ib(1);
            chk(lf_b, n - 1 > 3);
            ib(1);
            chk(lf_b, n > 3);
            chk({sp_a, hf_a}, {n < DEPTH, n + 4 < DEPTH});
        end
        pa(1'b1, 1'b0, BUS_SIZE_36, 36'h0);
        chk(36'(cnt[0]), 36'(DEPTH));
        // Drain queue 1; writer flags recover on the second port A edge
        for (int k = DEPTH - 1; k >= 0; k--)
        begin
            pb(1'b1, 1'b0, BUS_SIZE_36, '0);
            chk(db, qd_b);
            chk(lf_b, k > 3);
            ia(1);
            chk({sp_a, hf_a}, {k + 1 < DEPTH, k + 5 < DEPTH});
            ia(1);
            chk({sp_a, hf_a}, {1'b1, k + 4 < DEPTH});
        end
        pb(1'b1, 1'b0, BUS_SIZE_36, '0);
        chk(36'(cnt[1]), 36'(DEPTH));
        // Queue 2 word from port B to port A
        pb(1'b0, 1'b0, BUS_SIZE_36, 36'h5);
        ia(2);
        chk({34'(cnt[2]), lf_a, hf_b}, {34'h1, 2'h2});
        pa(1'b0, 1'b0, BUS_SIZE_36, '0);
        chk(da, qd_a);
        chk({35'(cnt[3]), lf_a}, {35'h1, 1'b0});
        ib(2);
        chk(hf_b, 1'b1);
        // Reset in mid-run clears pending mail
        pa(1'b1, 1'b1, BUS_SIZE_9, 36'h1ff);
        chk(mf_ab, 1'b0);
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        chk(mf_ab, 1'b1);
        // Release again: no output enable from the cleared synchroniser, flags at reset values
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk({oe_a, oe_b}, 2'h0);
        repeat (4) @(negedge clk);
        chk({sp_a, sp_b, hf_a, hf_b, lf_a, lf_b, mf_ab, mf_ba}, 8'h33);
        // Clock enable low: a whole port A mail write passes unseen
        clk_en = 1'b0;
        pa(1'b1, 1'b1, BUS_SIZE_36, 36'h0);
        clk_en = 1'b1;
        repeat (6) @(negedge clk);
        chk(mf_ab, 1'b1);
        pa(1'b1, 1'b1, BUS_SIZE_36, 36'h0);
        chk(mf_ab, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
